//--- hw/dim_cfg.svh
`ifndef DIM_CFG_SVH
`define DIM_CFG_SVH

// -------------------------------------------------------------
// register map (byte addresses, one word each)
// -------------------------------------------------------------
`define DIM_OFS_CTRL 12'h000
`define DIM_OFS_JOG_STEP 12'h004
`define DIM_OFS_INC_TOL 12'h008
`define DIM_OFS_DIR_TOL 12'h00c
`define DIM_OFS_STATUS 12'h010
`define DIM_OFS_TRAVEL 12'h014

// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define DIM_CTRL_POS_MODE 0
`define DIM_CTRL_ALARM_CLR 1
`define DIM_ST_INC_OK 0
`define DIM_ST_DIR_OK 1
`define DIM_ST_ALARM 2
`define DIM_ST_INC_ACTIVE 3

// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define DIM_RST_JOG_STEP 32'h0000_0000
`define DIM_RST_TOL 32'h0000_0000

`endif

//--- hw/dim_pkg.sv
`default_nettype none

package dim_pkg;
  // increment monitor sequencing
  typedef enum logic [1:0] {
    DIM_IDLE,
    DIM_RUN,
    DIM_TRIP
  } dim_state_t;

  // ahb-lite request captured in the address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } dim_req_t;

  // sampled axis inputs
  typedef struct packed {
    logic signed [31:0] speed;
    logic signed [31:0] pos;
  } dim_axis_t;
endpackage

`default_nettype wire

//--- hw/dim_monitor.sv
// How it works
// - jog active: track direction, accumulate relative travel
// - increment HI: direction matches, travel below limit
// - increment LO: opposing motion or travel over limit
// - both requests at once raise alarm
// - increment monitor idle until a request
// - jog-step limit register bounds relative travel
// - reverse-travel tolerance before increment trips
// - direction HI: speed not against request
// - direction LO: speed strictly against request
// - config selects speed or position evaluation
// - direction tolerance absorbs small reverse motion
//
// Chosen here: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "dim_cfg.svh"

module dim_monitor (
  input wire logic clk, // 125 mhz system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic sync_clear, // synchronous clear from the drive
  input wire logic mon_tick, // cyclic monitoring enable pulse
  input wire logic signed [31:0] axis_speed, // normalised speed from encoder interface
  input wire logic signed [31:0] axis_pos, // normalised position from encoder interface
  input wire logic right_direction_request, // from safety program
  input wire logic left_direction_request, // from safety program
  input wire logic hsel, // ahb-lite select
  input wire logic [31:0] haddr, // ahb-lite address
  input wire logic [1:0] htrans, // ahb-lite transfer type
  input wire logic hwrite, // ahb-lite direction
  input wire logic [2:0] hsize, // ahb-lite size
  input wire logic [31:0] hwdata, // ahb-lite write data
  input wire logic hready, // ahb-lite bus ready
  output logic [31:0] hrdata, // ahb-lite read data
  output logic hreadyout, // ahb-lite slave ready
  output logic hresp, // ahb-lite response, always okay
  output logic limited_increment_monitor, // increment monitor enable
  output logic direction_monitor, // direction monitor enable
  output logic alarm // impermissible request pair
);

  // -------------------------------------------------------------
  // input synchronisers
  // -------------------------------------------------------------
  // requests come from another logic domain, so two flops each
  logic [1:0] req_meta;
  logic [1:0] req_sync;
  dim_pkg::dim_axis_t axis_meta;
  dim_pkg::dim_axis_t axis_sync;

  // two stage synchroniser for the direction requests and axis words
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_meta <= 2'h0;
      req_sync <= 2'h0;
      axis_meta <= '0;
      axis_sync <= '0;
    end else begin
      req_meta <= {left_direction_request, right_direction_request};
      req_sync <= req_meta;
      axis_meta <= {axis_speed, axis_pos};
      axis_sync <= axis_meta;
    end
  end

  wire req_right = req_sync[0];
  wire req_left = req_sync[1];

  // -------------------------------------------------------------
  // configuration registers
  // -------------------------------------------------------------
  logic pos_mode; // 1: direction monitor evaluates position
  logic [31:0] jog_step; // maximum relative travel
  logic [31:0] inc_tol; // reverse travel tolerance, increment monitor
  logic [31:0] dir_tol; // reverse tolerance, direction monitor

  // -------------------------------------------------------------
  // ahb-lite slave
  // -------------------------------------------------------------
  dim_pkg::dim_req_t req_q; // latched address phase
  wire addr_phase = hsel && hready && htrans[1];
  wire wr_go = req_q.valid && req_q.write;
  wire rd_go = addr_phase && !hwrite;

  // capture the address phase for the following data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      req_q <= '0;
    end else if (hready) begin
      req_q <= '{valid: addr_phase, write: hwrite, addr: haddr[11:0]};
    end
  end

  // register writes land in the data phase; zero wait states
  logic alarm_clr_wr;
  assign alarm_clr_wr = wr_go && (req_q.addr == `DIM_OFS_CTRL) && hwdata[`DIM_CTRL_ALARM_CLR];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_mode <= 1'b0;
      jog_step <= `DIM_RST_JOG_STEP;
      inc_tol <= `DIM_RST_TOL;
      dir_tol <= `DIM_RST_TOL;
    end else if (wr_go) begin
      if (req_q.addr == `DIM_OFS_CTRL) begin
        pos_mode <= hwdata[`DIM_CTRL_POS_MODE];
      end
      if (req_q.addr == `DIM_OFS_JOG_STEP) begin
        jog_step <= hwdata;
      end
      if (req_q.addr == `DIM_OFS_INC_TOL) begin
        inc_tol <= hwdata;
      end
      if (req_q.addr == `DIM_OFS_DIR_TOL) begin
        dir_tol <= hwdata;
      end
    end
  end

  // -------------------------------------------------------------
  // increment monitor
  // -------------------------------------------------------------
  dim_pkg::dim_state_t state;
  dim_pkg::dim_state_t next_state;
  logic signed [31:0] start_pos; // position at activation
  logic [31:0] travel; // relative travel along request
  logic [31:0] reverse; // travel against request

  // magnitude of a signed word
  function automatic logic [31:0] dim_abs(input logic signed [31:0] v);
    dim_abs = v[31] ? 32'(-v) : 32'(v);
  endfunction

  wire one_req = req_right ^ req_left;
  wire both_req = req_right && req_left;
  wire signed [31:0] delta = 32'(axis_sync.pos - start_pos);
  // direction of travel from the position delta
  wire moved_right = !delta[31] && (delta != 32'h0000_0000);
  wire moved_left = delta[31];
  wire [31:0] along = (req_right && moved_right) || (req_left && moved_left) ? dim_abs(delta) : 32'h0000_0000;
  wire [31:0] against = (req_right && moved_left) || (req_left && moved_right) ? dim_abs(delta) : 32'h0000_0000;
  wire spd_pos = !axis_sync.speed[31] && (axis_sync.speed != 32'h0000_0000);
  wire spd_neg = axis_sync.speed[31];
  // speed matches request and travel under limit
  wire inc_good = ((spd_neg && req_left) || (spd_pos && req_right)) && (travel < jog_step);
  // over limit, or reverse beyond tolerance
  wire inc_bad = (travel > jog_step) || (reverse > inc_tol);

  // next state of the increment sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      dim_pkg::DIM_IDLE: if (one_req) next_state = dim_pkg::DIM_RUN;
      dim_pkg::DIM_RUN: begin
        if (!one_req) next_state = dim_pkg::DIM_IDLE;
        else if (inc_bad) next_state = dim_pkg::DIM_TRIP;
      end
      dim_pkg::DIM_TRIP: if (!one_req) next_state = dim_pkg::DIM_IDLE;
    endcase
  end

  // sequencer and travel accumulation, once per monitoring tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= dim_pkg::DIM_IDLE;
      start_pos <= '0;
      travel <= 32'h0000_0000;
      reverse <= 32'h0000_0000;
      limited_increment_monitor <= 1'b0;
    end else if (sync_clear) begin
      state <= dim_pkg::DIM_IDLE;
      travel <= 32'h0000_0000;
      reverse <= 32'h0000_0000;
      limited_increment_monitor <= 1'b0;
    end else if (mon_tick) begin
      state <= next_state;
      if (state == dim_pkg::DIM_IDLE) begin
        start_pos <= axis_sync.pos; // travel measured from start
        travel <= 32'h0000_0000;
        reverse <= 32'h0000_0000;
      end else begin
        travel <= along;
        reverse <= against;
      end
      // HI only while running and in range
      limited_increment_monitor <= (next_state == dim_pkg::DIM_RUN) && (state == dim_pkg::DIM_RUN) && inc_good;
    end
  end

  // -------------------------------------------------------------
  // direction monitor
  // -------------------------------------------------------------
  // position mode compares travel since start; speed mode speed itself
  wire [31:0] rev_mag = pos_mode ? reverse : dim_abs(axis_sync.speed);
  wire spd_against = (spd_neg && req_right) || (spd_pos && req_left);
  wire pos_against = reverse != 32'h0000_0000;
  wire dir_against = pos_mode ? pos_against : spd_against;
  // low without a single request; trip only when reverse exceeds tolerance
  wire dir_good = one_req && !(dir_against && (rev_mag > dir_tol));

  // direction output, evaluated once per tick
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      direction_monitor <= 1'b0;
    end else if (sync_clear) begin
      direction_monitor <= 1'b0;
    end else if (mon_tick) begin
      direction_monitor <= dir_good;
    end
  end

  // -------------------------------------------------------------
  // alarm
  // -------------------------------------------------------------
  // sticky; a new both-request event wins over a software clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      alarm <= 1'b0;
    end else if (sync_clear) begin
      alarm <= 1'b0;
    end else if (both_req) begin
      alarm <= 1'b1;
    end else if (alarm_clr_wr) begin
      alarm <= 1'b0;
    end
  end

  // -------------------------------------------------------------
  // read path
  // -------------------------------------------------------------
  wire [31:0] status_word = {28'h000_0000, state != dim_pkg::DIM_IDLE, alarm, direction_monitor,
    limited_increment_monitor};
  logic [31:0] rd_mux;

  // read mux; unmapped addresses read zero
  always_comb begin
    unique case (haddr[11:0])
      `DIM_OFS_CTRL: rd_mux = {31'h0000_0000, pos_mode};
      `DIM_OFS_JOG_STEP: rd_mux = jog_step;
      `DIM_OFS_INC_TOL: rd_mux = inc_tol;
      `DIM_OFS_DIR_TOL: rd_mux = dir_tol;
      `DIM_OFS_STATUS: rd_mux = status_word;
      `DIM_OFS_TRAVEL: rd_mux = travel;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data registered at the address phase so it stands in the data phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rd_go) hrdata <= rd_mux;
    end
  end

  // -------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------
  sequence both_seen;
    both_req && !sync_clear;
  endsequence

  AST_ALARM_SET: assert property (@(posedge clk) disable iff (!nrst) both_seen |=> alarm)
    else $error("alarm not raised for both requests");
  AST_IDLE_LOW: assert property (@(posedge clk) disable iff (!nrst)
    (state == dim_pkg::DIM_IDLE) && mon_tick |=> !limited_increment_monitor)
    else $error("increment output high while idle");
  AST_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
    sync_clear |=> !alarm && !direction_monitor && !limited_increment_monitor && travel == 32'h0000_0000)
    else $error("clear did not reset outputs");
  AST_OVER_LIMIT: assert property (@(posedge clk) disable iff (!nrst)
    mon_tick && !sync_clear && travel > jog_step |=> !limited_increment_monitor)
    else $error("increment high over limit");
  AST_INC_HI: assert property (@(posedge clk) disable iff (!nrst)
    limited_increment_monitor |-> state == dim_pkg::DIM_RUN)
    else $error("increment high outside run");
  AST_DIR_LO: assert property (@(posedge clk) disable iff (!nrst)
    mon_tick && !sync_clear && !pos_mode && spd_against && dim_abs(axis_sync.speed) > dir_tol
    |=> !direction_monitor)
    else $error("direction high against request");
  AST_DIR_HI: assert property (@(posedge clk) disable iff (!nrst)
    mon_tick && !sync_clear && !pos_mode && one_req && !spd_against |=> direction_monitor)
    else $error("direction low with matching speed");
  AST_TOL: assert property (@(posedge clk) disable iff (!nrst)
    mon_tick && !sync_clear && state == dim_pkg::DIM_RUN && one_req && reverse > inc_tol
    |=> state == dim_pkg::DIM_TRIP)
    else $error("reverse tolerance not enforced");
  AST_JOG_WR: assert property (@(posedge clk) disable iff (!nrst)
    wr_go && req_q.addr == `DIM_OFS_JOG_STEP |=> jog_step == $past(hwdata))
    else $error("jog step not written");
  AST_TRAVEL: assert property (@(posedge clk) disable iff (!nrst)
    mon_tick && !sync_clear && state == dim_pkg::DIM_RUN |=> travel == $past(along))
    else $error("travel not accumulated");
  AST_MODE: assert property (@(posedge clk) disable iff (!nrst)
    wr_go && req_q.addr == `DIM_OFS_CTRL |=> pos_mode == $past(hwdata[0]))
    else $error("monitoring type not written");
  AST_DIR_TOL: assert property (@(posedge clk) disable iff (!nrst)
    mon_tick && !sync_clear && one_req && !pos_mode && dim_abs(axis_sync.speed) <= dir_tol |=> direction_monitor)
    else $error("trip inside direction tolerance");

  // -------------------------------------------------------------
  // increment, direction and alarm step checks
  // -------------------------------------------------------------
  // a monitoring tick that no clear overrides
  sequence live_tick;
    mon_tick && !sync_clear;
  endsequence

  // a tick in run with one request kept and nothing out of range
  sequence run_in_range;
    live_tick ##0 ((state == dim_pkg::DIM_RUN) && one_req && !inc_bad);
  endsequence

  AST_INC_OPPOSE: assert property (@(posedge clk) disable iff (!nrst)
    live_tick ##0 spd_against |=> !limited_increment_monitor)
    else $error("increment high against request");
  AST_INC_RISE: assert property (@(posedge clk) disable iff (!nrst)
    run_in_range ##0 inc_good |=> limited_increment_monitor)
    else $error("increment low although in range");
  AST_TRIP_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    (state == dim_pkg::DIM_TRIP) && one_req && !sync_clear |=> state == dim_pkg::DIM_TRIP)
    else $error("trip released while request held");
  AST_ALARM_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    alarm && !sync_clear && !alarm_clr_wr |=> alarm)
    else $error("alarm dropped without a clear");
  AST_DIR_POS: assert property (@(posedge clk) disable iff (!nrst)
    live_tick ##0 (pos_mode && one_req && (reverse > dir_tol)) |=> !direction_monitor)
    else $error("direction high with reverse travel over tolerance");
  AST_START_POS: assert property (@(posedge clk) disable iff (!nrst)
    live_tick ##0 (state == dim_pkg::DIM_IDLE) |=> travel == 32'h0000_0000 && start_pos == $past(axis_sync.pos))
    else $error("start position not captured in idle");
  AST_NO_REQ: assert property (@(posedge clk) disable iff (!nrst)
    live_tick ##0 !one_req |=> !limited_increment_monitor && !direction_monitor)
    else $error("monitor output high without a single request");

endmodule

`default_nettype wire

//--- verification/dim_axis_model.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// encoder interface and safety program stand-in
// ------------------------------------------------------------
module dim_axis_model #(
  parameter int TICK_CYC = 4 // clocks between monitoring pulses
) (
  input wire logic clk, // system clock
  input wire logic nrst, // asynchronous reset, active low
  input wire logic signed [31:0] speed_cmd, // axis speed wanted by the bench
  input wire logic want_right, // bench asks for a right request
  input wire logic want_left, // bench asks for a left request
  input wire logic allow_both, // bench deliberately breaks the pairing rule
  output logic mon_tick, // one-cycle monitoring pulse
  output logic signed [31:0] axis_speed, // normalised speed
  output logic signed [31:0] axis_pos, // normalised position
  output logic right_direction_request, // to the monitor
  output logic left_direction_request // to the monitor
);
  int cnt; // tick spacing counter

  // the program never raises both requests unless a scenario orders it
  assign right_direction_request = want_right & (~want_left | allow_both);
  assign left_direction_request = want_left & (~want_right | allow_both);

  // position integrates speed once per tick, so travel is predictable
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 0;
      mon_tick <= 1'b0;
      axis_speed <= 32'sh0000_0000;
      axis_pos <= 32'sh0000_0000;
    end else begin
      axis_speed <= speed_cmd;
      mon_tick <= (cnt == TICK_CYC - 1);
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
      if (cnt == TICK_CYC - 1) begin
        axis_pos <= axis_pos + speed_cmd;
      end
    end
  end
endmodule

`default_nettype wire

//--- verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "dim_cfg.svh"

module testbench;
  localparam int TICK_CYC = 4; // clocks per monitoring tick
  logic clk = 1'b0; // 125 mhz
  logic nrst = 1'b0; // reset, active low
  logic sync_clear = 1'b0; // synchronous clear
  logic hsel = 1'b0; // bus select
  logic [31:0] haddr = 32'h0000_0000; // bus address
  logic [1:0] htrans = 2'h0; // bus transfer type
  logic hwrite = 1'b0; // bus direction
  logic [2:0] hsize = 3'h2; // always a whole word
  logic [31:0] hwdata = 32'h0000_0000; // bus write data
  logic [31:0] hrdata; // bus read data
  logic hresp; // bus response, must stay okay
  logic hreadyout; // slave ready, also the bus ready
  logic signed [31:0] speed_cmd = 32'sh0000_0000; // wanted speed
  logic want_right = 1'b0; // wanted right request
  logic want_left = 1'b0; // wanted left request
  logic allow_both = 1'b0; // permit the forbidden pair
  logic mon_tick, right_req, left_req, inc_ok, dir_ok, alarm; // monitor side
  logic signed [31:0] axis_speed, axis_pos; // axis side
  logic [31:0] rd; // last read word
  int n_mismatch = 0; // mismatches seen
  int n_compared = 0; // comparisons made
  // direction table: tolerance, speed, right or left, expected output
  logic [31:0] t_tol [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h4, 32'h4};
  logic signed [31:0] t_spd [8] = '{0, 0, -1, 1, 3, -3, -3, -10};
  logic t_right [8] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
  logic t_exp [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};

  always #4 clk = ~clk;

  dim_monitor i_dim_monitor (.clk(clk), .nrst(nrst), .sync_clear(sync_clear), .mon_tick(mon_tick),
    .axis_speed(axis_speed), .axis_pos(axis_pos), .right_direction_request(right_req),
    .left_direction_request(left_req), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .limited_increment_monitor(inc_ok), .direction_monitor(dir_ok), .alarm(alarm));

  dim_axis_model #(.TICK_CYC(TICK_CYC)) i_dim_axis_model (.clk(clk), .nrst(nrst), .speed_cmd(speed_cmd),
    .want_right(want_right), .want_left(want_left), .allow_both(allow_both), .mon_tick(mon_tick),
    .axis_speed(axis_speed), .axis_pos(axis_pos), .right_direction_request(right_req),
    .left_direction_request(left_req));

  // ------------------------------------------------------------
  // shared helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single ahb-lite transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0_0000, a};
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK_CYC) @(posedge clk);
  endtask

  task automatic drive(input logic signed [31:0] s, input logic r, input logic l);
    @(posedge clk);
    speed_cmd <= s;
    want_right <= r;
    want_left <= l;
  endtask

  // drop requests and let the monitors fall back to idle
  task automatic settle();
    drive(0, 1'b0, 1'b0);
    ticks(4);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    bus(1'b0, `DIM_OFS_JOG_STEP, 32'h0);
    check(rd, `DIM_RST_JOG_STEP);
    bus(1'b0, `DIM_OFS_INC_TOL, 32'h0);
    check(rd, `DIM_RST_TOL);
    bus(1'b0, `DIM_OFS_DIR_TOL, 32'h0);
    check(rd, `DIM_RST_TOL);
    bus(1'b0, `DIM_OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `DIM_OFS_STATUS, 32'hffff_ffff); // read-only place, write is dropped
    bus(1'b0, `DIM_OFS_STATUS, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, 12'h020, 32'hdead_beef); // unmapped
    bus(1'b0, 12'h020, 32'h0);
    check(rd, 32'h0);
    bus(1'b1, `DIM_OFS_JOG_STEP, 32'h0000_0064);
    bus(1'b0, `DIM_OFS_JOG_STEP, 32'h0);
    check(rd, 32'h0000_0064);
  endtask

  // speed present but nothing requested: increment stays inactive
  task automatic t_idle();
    drive(5, 1'b0, 1'b0);
    ticks(8);
    check({31'h0, inc_ok}, 32'h0);
    settle();
  endtask

  // jog of 5 per tick against a step of 100: ok early, tripped late
  task automatic t_jog();
    drive(5, 1'b1, 1'b0);
    ticks(5);
    check({31'h0, inc_ok}, 32'h1);
    bus(1'b0, `DIM_OFS_STATUS, 32'h0);
    check(rd[`DIM_ST_INC_ACTIVE], 1'b1);
    ticks(25);
    check({31'h0, inc_ok}, 32'h0);
    bus(1'b0, `DIM_OFS_TRAVEL, 32'h0);
    check({31'h0, rd > 32'h0000_0064}, 32'h1);
    settle();
    // left jog with negative speed is accepted the same way
    drive(-5, 1'b0, 1'b1);
    ticks(5);
    check({31'h0, inc_ok}, 32'h1);
    settle();
  endtask

  // reverse jog beyond a tolerance of 20
  task automatic t_reverse();
    bus(1'b1, `DIM_OFS_INC_TOL, 32'h0000_0014);
    drive(-5, 1'b1, 1'b0);
    ticks(12);
    check({31'h0, inc_ok}, 32'h0);
    // turning back to the right direction must not revive a tripped jog
    drive(5, 1'b1, 1'b0);
    ticks(3);
    check({31'h0, inc_ok}, 32'h0);
    settle();
  endtask

  // speed mode: sign boundaries in both directions, tolerance with a right request only
  task automatic t_dir();
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, `DIM_OFS_DIR_TOL, t_tol[i]);
      drive(t_spd[i], t_right[i], ~t_right[i]);
      ticks(4);
      check({31'h0, dir_ok}, {31'h0, t_exp[i]});
      settle();
    end
  endtask

  // position mode: wrong-way travel tolerated up to 30, then trips
  task automatic t_posmode();
    bus(1'b1, `DIM_OFS_CTRL, 32'h0000_0001);
    bus(1'b1, `DIM_OFS_DIR_TOL, 32'h0000_001e);
    drive(5, 1'b0, 1'b1);
    ticks(3);
    check({31'h0, dir_ok}, 32'h1);
    ticks(10);
    check({31'h0, dir_ok}, 32'h0);
    bus(1'b1, `DIM_OFS_CTRL, 32'h0);
    settle();
  endtask

  // forbidden pair raises a sticky alarm; software and sync clear drop it
  task automatic t_alarm();
    @(posedge clk);
    allow_both <= 1'b1;
    drive(0, 1'b1, 1'b1);
    repeat (5) @(posedge clk);
    check({31'h0, alarm}, 32'h1);
    settle();
    check({31'h0, alarm}, 32'h1);
    bus(1'b0, `DIM_OFS_STATUS, 32'h0);
    check(rd[`DIM_ST_ALARM], 1'b1);
    bus(1'b1, `DIM_OFS_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clk);
    check({31'h0, alarm}, 32'h0);
    drive(0, 1'b1, 1'b1);
    repeat (5) @(posedge clk);
    drive(0, 1'b0, 1'b0);
    allow_both <= 1'b0;
    repeat (3) @(posedge clk);
    sync_clear <= 1'b1;
    @(posedge clk);
    sync_clear <= 1'b0;
    repeat (2) @(posedge clk);
    check({30'h0, alarm, inc_ok}, 32'h0);
  endtask

  // ------------------------------------------------------------
  // run control
  // ------------------------------------------------------------
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // whole run is under a thousand cycles; this bound means a hang
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_idle();
    t_jog();
    t_reverse();
    t_dir();
    t_posmode();
    t_alarm();
    report_and_stop();
  end
endmodule

`default_nettype wire
